// ---- inc/css_pkg.sv ----
/*
  css_pkg: constants for the control signal source selector.
  Assumes a Wishbone classic register slave with 32-bit data.
*/
package css_pkg;

  // selection codes
  localparam logic [11:0] SEL_ON        = 12'h006;
  localparam logic [11:0] SEL_OFF       = 12'h007;
  localparam logic [11:0] SEL_RELEASE   = 12'h046;
  localparam logic [11:0] SEL_IN_LAST   = 12'h04D;
  localparam logic [11:0] SEL_OVERTEMP  = 12'h0AA;
  localparam logic [11:0] SEL_DOUT_ONE  = 12'h0AF;
  localparam logic [11:0] SEL_RELAY     = 12'h0B0;
  localparam logic [11:0] SEL_SHARED    = 12'h0B1;
  localparam logic [11:0] SEL_PCT_REACH = 12'h0B2;
  localparam logic [11:0] SEL_MAINS     = 12'h0B3;
  localparam logic [11:0] SEL_BREAKER   = 12'h0B4;
  localparam logic [11:0] SEL_MFO       = 12'h0B5;
  localparam logic [11:0] SEL_APP_MASK  = 12'h0D7;
  localparam logic [11:0] SEL_APP_WARN  = 12'h0D8;
  localparam logic [11:0] SEL_BACKLASH  = 12'h0DB;
  localparam logic [11:0] SEL_SVC_DCL   = 12'h108;
  localparam logic [11:0] SEL_SVC_FAN   = 12'h109;
  localparam logic [11:0] SEL_INV_FIRST = 12'h10E;
  localparam logic [11:0] SEL_INV_LAST  = 12'h115;
  localparam logic [11:0] SEL_SAFE_A_N  = 12'h11C;
  localparam logic [11:0] SEL_SAFE_B_N  = 12'h11D;
  localparam logic [11:0] SEL_SAFE_A    = 12'h124;
  localparam logic [11:0] SEL_SAFE_B    = 12'h125;
  localparam logic [11:0] SEL_POWER_ON  = 12'h143;
  localparam logic [11:0] SEL_ENERGY    = 12'h1D7;

  // mode values
  localparam logic [1:0] SVC_ALARM      = 2'h2;
  localparam logic [1:0] ES_MANUAL      = 2'h1;
  localparam logic [1:0] ES_AUTO        = 2'h2;
  localparam logic [2:0] LR_CONTACT     = 3'h0;
  localparam logic [2:0] LR_3WIRE_A     = 3'h4;
  localparam logic [2:0] LR_3WIRE_B     = 3'h5;

  // register map, byte offsets
  localparam logic [3:0] REG_SELECT     = 4'h0;
  localparam logic [3:0] REG_MODES      = 4'h4;
  localparam logic [3:0] REG_STATUS     = 4'h8;

  // field positions in the mode register
  localparam int MODE_LR_LSB   = 0;
  localparam int MODE_DCL_LSB  = 4;
  localparam int MODE_FAN_LSB  = 6;
  localparam int MODE_ES_LSB   = 8;

  localparam logic [11:0] SELECT_RST = 12'h007;
  localparam logic [9:0]  MODES_RST  = 10'h000;

endpackage

// ---- verilog/css_selector.sv ----
/*
  css_selector: picks one drive-internal logic signal by selection code and
  registers it. Assumes sources from monitoring logic arrive on clk_i;
  terminal and safety inputs arrive asynchronously and are synchronised here.
*/
`timescale 1ns/10ps

module css_selector
  import css_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // asynchronous terminal inputs
  input  wire logic        safety_enable_a_i,
  input  wire logic        safety_enable_b_i,
  input  wire logic        digital_input_one_i,
  input  wire logic        digital_input_two_i,
  input  wire logic        digital_input_three_i,
  input  wire logic        digital_input_four_i,
  input  wire logic        digital_input_five_i,
  input  wire logic        multifunction_input_one_i,
  input  wire logic        multifunction_input_two_i,
  // remote-mode equivalents, same clock
  input  wire logic        remote_release_i,
  input  wire logic [6:0]  remote_inputs_i,
  // monitoring sources, same clock
  input  wire logic        heat_sink_warn_i,
  input  wire logic        inside_warn_i,
  input  wire logic        digital_output_one_i,
  input  wire logic        relay_output_i,
  input  wire logic        shared_terminal_output_i,
  input  wire logic        pct_reached_i,
  input  wire logic        mains_failed_i,
  input  wire logic        power_reg_active_i,
  input  wire logic        breaker_trip_i,
  input  wire logic        multifunction_output_digital_i,
  input  wire logic        app_mask_critical_i,
  input  wire logic        app_warning_i,
  input  wire logic        deviation_in_band_i,
  input  wire logic        dcl_service_expired_i,
  input  wire logic        fan_service_expired_i,
  input  wire logic        mains_present_i,
  input  wire logic        precharge_done_i,
  input  wire logic        energy_switch_on_i,
  output logic             selected_o
);

  localparam int NSYNC = 9;

  logic [11:0]      select_q;
  logic [9:0]       modes_q;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic             selected_d;
  logic             ack_d;
  logic             bus_req;
  logic [31:0]      rdata;
  logic [7:0]       in_vec;
  logic             contacts_ok;
  logic [2:0]       lr_mode;
  logic [1:0]       dcl_mode;
  logic [1:0]       fan_mode;
  logic [1:0]       es_mode;
  logic [31:0]      select_wr;
  logic [31:0]      modes_wr;

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign bus_req  = cyc_i & stb_i & ~ack_o;
  assign lr_mode  = modes_q[MODE_LR_LSB +: 3];
  assign dcl_mode = modes_q[MODE_DCL_LSB +: 2];
  assign fan_mode = modes_q[MODE_FAN_LSB +: 2];
  assign es_mode  = modes_q[MODE_ES_LSB +: 2];

  // lane-merged write values
  assign select_wr = merge({20'h00000, select_q}, dat_i, sel_i);
  assign modes_wr  = merge({22'h000000, modes_q}, dat_i, sel_i);

  // two-flop synchroniser for pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= {multifunction_input_two_i, multifunction_input_one_i,
                 digital_input_five_i, digital_input_four_i, digital_input_three_i,
                 digital_input_two_i, digital_input_one_i,
                 safety_enable_b_i, safety_enable_a_i};
      sync_q <= meta_q;
    end
  end

  assign contacts_ok = (lr_mode == LR_CONTACT) || (lr_mode == LR_3WIRE_A) ||
                       (lr_mode == LR_3WIRE_B);

  always_comb begin
    if (contacts_ok) begin
      in_vec = {sync_q[8:2], sync_q[0] & sync_q[1]};
    end else begin
      in_vec = {remote_inputs_i, remote_release_i};
    end
  end

  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_q <= SELECT_RST;
      modes_q  <= MODES_RST;
    end else if (ce_i && bus_req && we_i) begin
      if (adr_i == REG_SELECT) begin
        select_q <= select_wr[11:0];
      end
      if (adr_i == REG_MODES) begin
        modes_q <= modes_wr[9:0];
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    unique case (adr_i)
      REG_SELECT: rdata = {20'h00000, select_q};
      REG_MODES:  rdata = {22'h000000, modes_q};
      REG_STATUS: rdata = {31'h00000000, selected_o};
      default:    rdata = 32'h00000000;
    endcase
  end

  assign ack_d = bus_req;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= ack_d;
      dat_o <= ack_d ? rdata : 32'h00000000;
    end
  end

  // source selection
  always_comb begin
    selected_d = 1'b0;
    if (select_q >= SEL_RELEASE && select_q <= SEL_IN_LAST) begin
      selected_d = in_vec[3'(select_q - SEL_RELEASE)];
    end else if (select_q >= SEL_INV_FIRST && select_q <= SEL_INV_LAST) begin
      selected_d = ~in_vec[3'(select_q - SEL_INV_FIRST)];
    end else begin
      unique case (select_q)
        SEL_ON:        selected_d = 1'b1;
        SEL_OVERTEMP:  selected_d = heat_sink_warn_i | inside_warn_i;
        SEL_DOUT_ONE:  selected_d = digital_output_one_i;
        SEL_RELAY:     selected_d = relay_output_i;
        SEL_SHARED:    selected_d = shared_terminal_output_i;
        SEL_PCT_REACH: selected_d = pct_reached_i;
        SEL_MAINS:     selected_d = mains_failed_i & power_reg_active_i;
        SEL_BREAKER:   selected_d = breaker_trip_i;
        SEL_MFO:       selected_d = multifunction_output_digital_i;
        SEL_APP_MASK:  selected_d = app_mask_critical_i;
        SEL_APP_WARN:  selected_d = app_warning_i;
        SEL_BACKLASH:  selected_d = deviation_in_band_i;
        SEL_SVC_DCL:   selected_d = dcl_service_expired_i & (dcl_mode == SVC_ALARM);
        SEL_SVC_FAN:   selected_d = fan_service_expired_i & (fan_mode == SVC_ALARM);
        SEL_SAFE_A_N:  selected_d = ~sync_q[0];
        SEL_SAFE_B_N:  selected_d = ~sync_q[1];
        SEL_SAFE_A:    selected_d = sync_q[0];
        SEL_SAFE_B:    selected_d = sync_q[1];
        SEL_POWER_ON:  selected_d = mains_present_i & precharge_done_i;
        SEL_ENERGY:    selected_d = energy_switch_on_i &
                                    ((es_mode == ES_MANUAL) || (es_mode == ES_AUTO));
        default:       selected_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      selected_o <= 1'b0;
    end else if (ce_i) begin
      selected_o <= selected_d;
    end
  end

endmodule // css_selector

// ---- tb/css_assertions.sv ----
/* css_assertions: checker on the css_selector ports.
   assumes full-lane writes and ce_i mostly high. */
`timescale 1ns/10ps
module css_chk
  import css_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        selected_o,
  input wire logic        safety_enable_a_i,
  input wire logic        heat_sink_warn_i,
  input wire logic        inside_warn_i
);
  logic [11:0] code_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // code as seen on the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) code_q <= SELECT_RST;
    else if (ack_o && we_i && adr_i == REG_SELECT) code_q <= dat_i[11:0];
  end
  property p_ack_next;
    cyc_i && stb_i && ce_i && !ack_o |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat_zero;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("data without ack");
  property p_on;
    code_q == SEL_ON |-> selected_o;
  endproperty
  a_on: assert property (p_on) else $error("on code low");
  property p_unused;
    code_q == SEL_OFF || code_q == 12'h001 |-> !selected_o;
  endproperty
  a_unused: assert property (p_unused) else $error("unused code high");
  property p_hot;
    code_q == SEL_OVERTEMP |-> selected_o == $past(heat_sink_warn_i || inside_warn_i);
  endproperty
  a_hot: assert property (p_hot) else $error("overtemp wrong");
  property p_safe;
    (code_q == SEL_SAFE_A && $stable(safety_enable_a_i))[*5] |-> selected_o == safety_enable_a_i;
  endproperty
  a_safe: assert property (p_safe) else $error("safety level wrong");
  property p_safe_n;
    (code_q == SEL_SAFE_A_N && $stable(safety_enable_a_i))[*5] |-> selected_o != safety_enable_a_i;
  endproperty
  a_safe_n: assert property (p_safe_n) else $error("safety inverse wrong");
  c_wr: cover property (ack_o && we_i);
  c_hot: cover property (code_q == SEL_OVERTEMP && selected_o);
  c_safe: cover property (code_q == SEL_SAFE_A_N && selected_o);
endmodule // css_chk
bind css_selector css_chk i_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .dat_i, .dat_o, .ack_o, .selected_o, .safety_enable_a_i, .heat_sink_warn_i, .inside_warn_i);

// ---- tb/css_source_model.sv ----
/* css_source_model: monitoring sources and terminal pins.
   assumes the bench sets the wanted levels. */
`timescale 1ns/10ps
module css_source_model (
  input  wire logic        clk_i,
  input  wire logic [18:0] mon_i,
  input  wire logic [8:0]  pin_i,
  output logic      [18:0] mon_o,
  output logic      [8:0]  pin_o
);
  // monitors change on the clock
  always_ff @(posedge clk_i) mon_o <= mon_i;
  // contacts change off the edge
  always_ff @(negedge clk_i) pin_o <= pin_i;
endmodule // css_source_model

// ---- tb/test_control_signal_source_selector.sv ----
/* test_control_signal_source_selector: bench for css_selector.
   assumes the source model and the bound checker. */
`timescale 1ns/10ps
module test_control_signal_source_selector
  import css_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [3:0]  adr_i = 0, sel_i = 4'hF;
  logic [31:0] dat_i = 0, dat_o, q;
  logic        ack_o, selected_o;
  logic [18:0] m, mr = 0;
  logic [8:0]  p, pr = 0;
  logic [6:0]  remote_inputs_i = 0;
  logic [11:0] cs [9] = '{SEL_DOUT_ONE, SEL_RELAY, SEL_SHARED, SEL_PCT_REACH, SEL_BREAKER,
                          SEL_MFO, SEL_APP_MASK, SEL_APP_WARN, SEL_BACKLASH};
  int          cb [9] = '{2, 3, 4, 5, 8, 9, 10, 11, 12};
  logic [2:0]  lrs [3] = '{3'h0, 3'h4, 3'h5};
  int          miscompares = 0, comparisons = 0, cycles = 0;
  css_source_model i_src (.clk_i, .mon_i(mr), .pin_i(pr), .mon_o(m), .pin_o(p));
  css_selector i_dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .safety_enable_a_i(p[0]), .safety_enable_b_i(p[1]),
    .digital_input_one_i(p[2]), .digital_input_two_i(p[3]), .digital_input_three_i(p[4]),
    .digital_input_four_i(p[5]), .digital_input_five_i(p[6]),
    .multifunction_input_one_i(p[7]), .multifunction_input_two_i(p[8]),
    .remote_release_i(m[18]), .remote_inputs_i, .heat_sink_warn_i(m[0]),
    .inside_warn_i(m[1]), .digital_output_one_i(m[2]), .relay_output_i(m[3]),
    .shared_terminal_output_i(m[4]), .pct_reached_i(m[5]), .mains_failed_i(m[6]),
    .power_reg_active_i(m[7]), .breaker_trip_i(m[8]), .multifunction_output_digital_i(m[9]),
    .app_mask_critical_i(m[10]), .app_warning_i(m[11]), .deviation_in_band_i(m[12]),
    .dcl_service_expired_i(m[13]), .fan_service_expired_i(m[14]), .mains_present_i(m[15]),
    .precharge_done_i(m[16]), .energy_switch_on_i(m[17]), .selected_o);
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic md(input logic [2:0] lr, input logic [1:0] dc, fan, es);
    wb(1'b1, REG_MODES, {22'h0, es, fan, dc, 1'b0, lr});
  endtask
  task automatic tc(input logic [11:0] c, input logic [18:0] mv, input logic [8:0] pv,
                    input logic e);
    wb(1'b1, REG_SELECT, {20'h0, c});
    mr <= mv;
    pr <= pv;
    repeat (4) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", q, {31'h0, e});
    chk("selected", {31'h0, selected_o}, {31'h0, e});
  endtask
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_SELECT, 32'h0);
    chk("select", q, {20'h0, SELECT_RST});
    wb(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, REG_MODES, 32'hFFFFFFFF);
    wb(1'b0, REG_MODES, 32'h0);
    chk("modes", q, 32'h3FF);
    md(3'h0, 2'h2, 2'h2, 2'h1);
    tc(SEL_ON, 19'h0, 9'h0, 1'b1);
    tc(12'h001, 19'h7FFFF, 9'h1FF, 1'b0);
    tc(SEL_OVERTEMP, 19'h1, 9'h0, 1'b1);
    tc(SEL_OVERTEMP, 19'h2, 9'h0, 1'b1);
    tc(SEL_OVERTEMP, 19'h7FFFC, 9'h0, 1'b0);
    for (int i = 0; i < 9; i++) begin
      tc(cs[i], 19'h1 << cb[i], 9'h0, 1'b1);
      tc(cs[i], ~(19'h1 << cb[i]), 9'h0, 1'b0);
    end
    tc(SEL_MAINS, 19'h40, 9'h0, 1'b0);
    tc(SEL_MAINS, 19'hC0, 9'h0, 1'b1);
    tc(SEL_POWER_ON, 19'h8000, 9'h0, 1'b0);
    tc(SEL_POWER_ON, 19'h18000, 9'h0, 1'b1);
    tc(SEL_SVC_DCL, 19'h2000, 9'h0, 1'b1);
    tc(SEL_SVC_FAN, 19'h4000, 9'h0, 1'b1);
    tc(SEL_ENERGY, 19'h20000, 9'h0, 1'b1);
    tc(SEL_SAFE_A, 19'h0, 9'h1, 1'b1);
    tc(SEL_SAFE_B, 19'h0, 9'h1, 1'b0);
    tc(SEL_SAFE_A_N, 19'h0, 9'h1, 1'b0);
    tc(SEL_SAFE_B_N, 19'h0, 9'h1, 1'b1);
    tc(SEL_SAFE_A_N, 19'h0, 9'h0, 1'b1);
    md(3'h1, 2'h1, 2'h3, 2'h2);
    tc(SEL_SVC_DCL, 19'h2000, 9'h0, 1'b0);
    tc(SEL_SVC_FAN, 19'h4000, 9'h0, 1'b0);
    tc(SEL_ENERGY, 19'h20000, 9'h0, 1'b1);
    tc(SEL_SAFE_B, 19'h0, 9'h2, 1'b1);
    tc(SEL_RELEASE + 12'h1, 19'h0, 9'h1FF, 1'b0);
    tc(SEL_RELEASE, 19'h40000, 9'h0, 1'b1);
    remote_inputs_i <= 7'h40;
    tc(SEL_IN_LAST, 19'h0, 9'h0, 1'b1);
    remote_inputs_i <= 7'h00;
    md(3'h0, 2'h0, 2'h0, 2'h3);
    tc(SEL_ENERGY, 19'h20000, 9'h0, 1'b0);
    $display("test sources done");
    foreach (lrs[k]) begin
      md(lrs[k], 2'h0, 2'h0, 2'h0);
      tc(SEL_RELEASE, 19'h0, 9'h3, 1'b1);
      tc(SEL_RELEASE, 19'h40000, 9'h1, 1'b0);
      tc(SEL_INV_FIRST, 19'h0, 9'h3, 1'b0);
      for (int i = 0; i < 7; i++) begin
        tc(SEL_RELEASE + 12'(i + 1), 19'h0, 9'h4 << i, 1'b1);
        tc(SEL_INV_FIRST + 12'(i + 1), 19'h0, 9'h4 << i, 1'b0);
        tc(SEL_INV_FIRST + 12'(i + 1), 19'h0, ~(9'h4 << i), 1'b1);
      end
    end
    $display("test contacts done");
    print_verdict();
  end
endmodule // test_control_signal_source_selector
